// *** hw/ars_pkg.sv ***
// Package with timing constants and state types of the ACPI rail sequencer.
package ars_pkg;
   localparam int unsigned CLK_MHZ        = 100;
   localparam int unsigned DEGLITCH_NS    = 2000;
   localparam int unsigned SLEEP_DELAY_US = 200;
   localparam int unsigned LATCH_DELAY_MS = 3;
   localparam int unsigned ACTIVE_WAIT_MS = 25;
   localparam int unsigned DEGLITCH_CYC   = (DEGLITCH_NS * CLK_MHZ) / 1000;
   localparam int unsigned SLEEP_DELAY_CYC = SLEEP_DELAY_US * CLK_MHZ;
   localparam int unsigned LATCH_DELAY_CYC = LATCH_DELAY_MS * 1000 * CLK_MHZ;
   localparam int unsigned ACTIVE_WAIT_CYC = ACTIVE_WAIT_MS * 1000 * CLK_MHZ;
   localparam int unsigned CNT_W          = 24;
   localparam logic [1:0]  MEM_SEL_RST    = 2'h3;
   typedef enum logic [3:0] {
      ARS_OFF, ARS_SB_RAMP, ARS_SB_WAIT, ARS_SLP_RAMP, ARS_SLEEP,
      ARS_ACT_WAIT, ARS_ACT_RAMP, ARS_ACTIVE, ARS_TO_SLEEP, ARS_LATCHED
   } ars_state_t;
endpackage : ars_pkg

// *** hw/ars_sequencer.sv ***
// Control logic of the multi-rail ACPI power sequencer.
// Functional notes
// - Start standby rail soft-start once bias power-on reset releases.
// - About 3 ms after standby ramp, latch dual-5V support, ramp other rails.
// - Dual 5V on in active; in sleep only when support latched 1.
// - S5 low with S3 high keeps state except in S3 sleep, which wakes to active; no direct S3 to S5 changes.
// - Only active-to-sleep and sleep-to-active transitions are taken.
// - Dual-5V support follows input only in active, reset, shutdown, first 3 ms.
// - Both sleep requests deglitched by a 2 us filter.
// - S3 request fall starts 200 us timer; then S5 or S3 chosen.
// - Fast charge to 1 V, slow charge; ramp outputs from 1.25 V.
// - Standby rail good and node at 2.75 V arms its monitor, discharges node.
// - After timeout latch selections, second ramp, arm remaining monitors at 2.75 V.
// - Wake active when both requests high; switches wait 25 ms after inputs good.
// - Active timeout ramps memory and clock rails, raises switch gate.
// - In active, node discharged to 2.45 V and held until sleep request.
// - 3.3 V memory rail in sleep only if selected; always on in active.
// - Fault output high on any monitored output undervoltage.
// - External-rail undervoltage flags only; a memory-rail one latches off that rail, a clock one turns the clock rail off while present.
// - Soft-start shutdown turns all off, clears fault and latched regulators.
// - Early standby undervoltage latches whole device until bias cycles.
// - Overtemp 140 C flags fault; 155 C shuts off until back below 140 C.
// - Input loss in active forces S5 with fault until recovery or reset.
// - Capture dual-5V support on sleep entry, reset release, shutdown exit.
// - Latch memory select after standby ramp, reset, shutdown exit, S5 exit only.
`timescale 1ns/1ps
module ars_sequencer #(
   parameter int unsigned LATCH_CYC  = ars_pkg::LATCH_DELAY_CYC,  // 3 ms timeout
   parameter int unsigned ACTIVE_CYC = ars_pkg::ACTIVE_WAIT_CYC   // 25 ms timeout
) (
   input  wire logic       clk_i,                   // 100 MHz clock
   input  wire logic       sys_rst_i,               // Synchronous reset, active high
   input  wire logic       bias_por_ok_i,           // Bias above reset threshold
   input  wire logic       suspend_ram_request_n_i, // S3 sleep request, active low
   input  wire logic       soft_off_request_n_i,    // S5 sleep request, active low
   input  wire logic       dual5_sleep_support_i,   // Dual 5V sleep support select
   input  wire logic [1:0] memory_rail_select_i,    // Bit0 2.5 V mem, bit1 3.3 V mem
   input  wire logic       main_inputs_ok_i,        // 3.3, 5 and 12 V inputs good
   input  wire logic       ss_above_1v_i,           // Soft-start node above 1 V
   input  wire logic       ss_above_1v25_i,         // Soft-start node above 1.25 V
   input  wire logic       ss_above_2v75_i,         // Soft-start node above 2.75 V
   input  wire logic       ss_shutdown_i,           // Soft-start node below 0.8 V
   input  wire logic [4:0] rail_uv_i,               // UV: sb, mem33, mem25, clk, dual5
   input  wire logic       temp_warn_i,             // Temperature above 140 C
   input  wire logic       temp_shut_i,             // Temperature above 155 C
   output logic            ss_fast_charge_o,        // Fast charge soft-start node
   output logic            ss_slow_charge_o,        // Slow charge current on
   output logic            ss_discharge_1v25_o,     // Discharge node to 1.25 V
   output logic            ss_discharge_2v45_o,     // Discharge node to 2.45 V
   output logic            standby_rail_en_o,       // Standby 3.3 V regulator on
   output logic            active_switch_gate_o,    // Active pass switch gate
   output logic            dual_five_output_o,      // Dual 5V output enable
   output logic            mem33_sleep_en_o,        // Internal 3.3 V memory pass on
   output logic            mem25_en_o,              // 2.5 V memory regulator on
   output logic            clock_rail_output_o,     // 2.5 V clock regulator on
   output logic            fault_o,                 // Fault report, active high
   output logic            in_sleep_s5_o            // Device in S5 state
);
   ars_pkg::ars_state_t       st_q, st_d;
   logic [ars_pkg::CNT_W-1:0] tmr_q, tmr_d;
   logic [1:0]                s3_sy_q, s5_sy_q, s3_sy_d, s5_sy_d;
   logic [1:0]                s3_m_q, s5_m_q, s3_m_d, s5_m_d, mem_sy_q, mem_sy_d;
   logic [7:0]                g3_q, g5_q, g3_d, g5_d;
   logic                      s3_f_q, s5_f_q, s3_f_d, s5_f_d;
   logic                      d5_q, d5_d, dual5_pass_q, dual5_pass_d;
   logic [1:0]                mem_sel_q, mem_sel_d;
   logic                      sb_armed_q, sb_armed_d, all_armed_q, all_armed_d;
   logic                      disch_q, disch_d, forced_q, forced_d, hot_q, hot_d, loss_q, loss_d;
   logic [1:0]                loff_q, loff_d;
   logic                      uv_any;
   logic                      outs_on;
   logic                      ss_fast_d, ss_slow_d, d125_d, d245_d, sb_en_d, gate_d;
   logic                      d5o_d, m33_d, m25_d, clk_d, flt_d, s5o_d;

   // Deglitch helper: counts while the sample differs from the filtered level.
   function automatic logic [7:0] glitch_cnt(input logic smp, input logic filt,
                                             input logic [7:0] cnt);
      if (smp == filt) begin
         glitch_cnt = 8'h00;
      end else begin
         glitch_cnt = cnt + 8'h01;
      end
   endfunction : glitch_cnt

   // Input synchronisers and sleep request filters.
   always_comb begin
      s3_sy_d = {s3_sy_q[0], suspend_ram_request_n_i};
      s5_sy_d = {s5_sy_q[0], soft_off_request_n_i};
      s3_m_d  = {s3_m_q[0], dual5_sleep_support_i};
      mem_sy_d = memory_rail_select_i;
      s5_m_d  = mem_sy_q;
      g3_d    = glitch_cnt(s3_sy_q[1], s3_f_q, g3_q);
      g5_d    = glitch_cnt(s5_sy_q[1], s5_f_q, g5_q);
      s3_f_d  = s3_f_q;
      s5_f_d  = s5_f_q;
      if (g3_q == 8'(ars_pkg::DEGLITCH_CYC)) begin
         s3_f_d = s3_sy_q[1];
         g3_d   = 8'h00;
      end
      if (g5_q == 8'(ars_pkg::DEGLITCH_CYC)) begin
         s5_f_d = s5_sy_q[1];
         g5_d   = 8'h00;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s3_sy_q <= 2'h3;
         s5_sy_q <= 2'h3;
         s3_m_q  <= 2'h0;
         mem_sy_q <= ars_pkg::MEM_SEL_RST;
         s5_m_q  <= ars_pkg::MEM_SEL_RST;
         g3_q    <= 8'h00;
         g5_q    <= 8'h00;
         s3_f_q  <= 1'b1;
         s5_f_q  <= 1'b1;
      end else begin
         s3_sy_q <= s3_sy_d;
         s5_sy_q <= s5_sy_d;
         s3_m_q  <= s3_m_d;
         mem_sy_q <= mem_sy_d;
         s5_m_q  <= s5_m_d;
         g3_q    <= g3_d;
         g5_q    <= g5_d;
         s3_f_q  <= s3_f_d;
         s5_f_q  <= s5_f_d;
      end
   end

   assign uv_any  = |(rail_uv_i & {{4{all_armed_q}}, sb_armed_q});
   assign outs_on = !ss_shutdown_i && !hot_q && st_q != ars_pkg::ARS_LATCHED;

   // Sequencer state, timers, latched selections and fault bookkeeping.
   always_comb begin
      st_d         = st_q;
      tmr_d        = tmr_q;
      d5_d         = d5_q;
      mem_sel_d    = mem_sel_q;
      sb_armed_d   = sb_armed_q;
      all_armed_d  = all_armed_q;
      disch_d      = 1'b0;
      forced_d     = forced_q;
      loss_d       = loss_q;
      loff_d       = loff_q;
      dual5_pass_d = dual5_pass_q;
      hot_d        = temp_shut_i ? 1'b1 : (temp_warn_i ? hot_q : 1'b0);
      if (st_q == ars_pkg::ARS_ACTIVE || tmr_q != '0 && st_q == ars_pkg::ARS_SB_WAIT) begin
         d5_d = s3_m_q[1];
      end
      if (all_armed_q) begin
         loff_d = loff_q | {rail_uv_i[2], rail_uv_i[1]};
      end
      if (!bias_por_ok_i) begin
         st_d        = ars_pkg::ARS_OFF;
         sb_armed_d  = 1'b0;
         all_armed_d = 1'b0;
         {forced_d, loss_d} = 2'h0;
         loff_d      = 2'h0;
         d5_d        = s3_m_q[1];
      end else if (st_q == ars_pkg::ARS_LATCHED) begin
         st_d = ars_pkg::ARS_LATCHED;
      end else if (ss_shutdown_i) begin
         st_d        = ars_pkg::ARS_OFF;
         {forced_d, loss_d} = 2'h0;
         loff_d      = 2'h0;
         all_armed_d = 1'b0;
         sb_armed_d  = 1'b0;
         d5_d        = s3_m_q[1];
      end else if (sb_armed_q && !all_armed_q && rail_uv_i[0]) begin
         st_d = ars_pkg::ARS_LATCHED;
      end else if ((st_q == ars_pkg::ARS_ACT_RAMP || st_q == ars_pkg::ARS_ACTIVE)
                   && !main_inputs_ok_i) begin
         {forced_d, loss_d} = 2'h3;
         d5_d = s3_m_q[1];
         st_d = ars_pkg::ARS_SLEEP;
      end else begin
         case (st_q)
            ars_pkg::ARS_OFF: begin
               st_d  = ars_pkg::ARS_SB_RAMP;
               d5_d  = s3_m_q[1];
               mem_sel_d = s5_m_q;
            end
            ars_pkg::ARS_SB_RAMP: begin
               if (ss_above_2v75_i && !rail_uv_i[0]) begin
                  sb_armed_d = 1'b1;
                  disch_d    = 1'b1;
                  tmr_d      = ars_pkg::CNT_W'(LATCH_CYC);
                  st_d       = ars_pkg::ARS_SB_WAIT;
               end
            end
            ars_pkg::ARS_SB_WAIT: begin
               if (tmr_q != '0) begin
                  tmr_d = tmr_q - 1'b1;
               end else begin
                  d5_d   = s3_m_q[1];
                  mem_sel_d = s5_m_q;
                  if (s3_f_q && s5_f_q) begin
                     st_d = ars_pkg::ARS_ACT_WAIT;
                     tmr_d = ars_pkg::CNT_W'(ACTIVE_CYC);
                  end else begin
                     st_d = ars_pkg::ARS_SLP_RAMP;
                     forced_d = !s5_f_q;
                  end
               end
            end
            ars_pkg::ARS_SLP_RAMP: begin
               if (ss_above_2v75_i) begin
                  all_armed_d = 1'b1;
                  disch_d     = 1'b1;
                  st_d        = ars_pkg::ARS_SLEEP;
               end
            end
            ars_pkg::ARS_SLEEP: begin
               if (s3_f_q && (s5_f_q || !forced_q) && (!forced_q || main_inputs_ok_i)) begin
                  if (forced_q) begin
                     mem_sel_d = s5_m_q;
                  end
                  {forced_d, loss_d} = 2'h0;
                  st_d     = ars_pkg::ARS_ACT_WAIT;
                  tmr_d    = ars_pkg::CNT_W'(ACTIVE_CYC);
               end
            end
            ars_pkg::ARS_ACT_WAIT: begin
               if (!main_inputs_ok_i) begin
                  tmr_d = ars_pkg::CNT_W'(ACTIVE_CYC);
               end else if (tmr_q != '0) begin
                  tmr_d = tmr_q - 1'b1;
               end else begin
                  st_d = ars_pkg::ARS_ACT_RAMP;
               end
            end
            ars_pkg::ARS_ACT_RAMP: begin
               if (ss_above_2v75_i) begin
                  all_armed_d = 1'b1;
                  st_d        = ars_pkg::ARS_ACTIVE;
               end
            end
            ars_pkg::ARS_ACTIVE: begin
               if (!s3_f_q) begin
                  st_d  = ars_pkg::ARS_TO_SLEEP;
                  tmr_d = ars_pkg::CNT_W'(ars_pkg::SLEEP_DELAY_CYC);
               end
            end
            ars_pkg::ARS_TO_SLEEP: begin
               if (s3_f_q) begin
                  st_d = ars_pkg::ARS_ACTIVE;
               end else if (tmr_q != '0) begin
                  tmr_d = tmr_q - 1'b1;
               end else begin
                  forced_d = !s5_f_q;
                  d5_d     = s3_m_q[1];
                  st_d     = ars_pkg::ARS_SLEEP;
               end
            end
            default: begin
               st_d = ars_pkg::ARS_OFF;
            end
         endcase
      end
      dual5_pass_d = d5_q;
   end

   // Output decode: every output registered.
   always_comb begin
      ss_fast_d = bias_por_ok_i && !ss_shutdown_i && !ss_above_1v_i;
      ss_slow_d = bias_por_ok_i && !ss_shutdown_i && ss_above_1v_i && !ss_above_2v75_i;
      d125_d    = disch_q && st_q != ars_pkg::ARS_ACTIVE;
      d245_d    = st_q == ars_pkg::ARS_ACTIVE && ss_above_2v75_i;
      sb_en_d   = outs_on && st_q != ars_pkg::ARS_OFF && ss_above_1v25_i;
      gate_d    = outs_on && (st_q == ars_pkg::ARS_ACT_RAMP || st_q == ars_pkg::ARS_ACTIVE
                  || st_q == ars_pkg::ARS_TO_SLEEP);
      d5o_d     = gate_d || (outs_on && st_q == ars_pkg::ARS_SLEEP && dual5_pass_q);
      m33_d     = outs_on && st_q == ars_pkg::ARS_SLEEP && mem_sel_q[1] && !loff_q[0];
      m25_d     = outs_on && (gate_d || st_q == ars_pkg::ARS_SLEEP && mem_sel_q[0])
                  && !loff_q[1];
      clk_d     = gate_d && !rail_uv_i[3];
      flt_d     = !ss_shutdown_i && (uv_any || temp_warn_i || temp_shut_i || loss_q
                  || st_q == ars_pkg::ARS_LATCHED);
      s5o_d     = st_q == ars_pkg::ARS_SLEEP && forced_q;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_q                 <= ars_pkg::ARS_OFF;
         tmr_q                <= '0;
         d5_q                 <= 1'b0;
         dual5_pass_q         <= 1'b0;
         mem_sel_q            <= ars_pkg::MEM_SEL_RST;
         sb_armed_q           <= 1'b0;
         all_armed_q          <= 1'b0;
         disch_q              <= 1'b0;
         forced_q             <= 1'b0;
         loss_q               <= 1'b0;
         loff_q               <= 2'h0;
         hot_q                <= 1'b0;
         ss_fast_charge_o     <= 1'b0;
         ss_slow_charge_o     <= 1'b0;
         ss_discharge_1v25_o  <= 1'b0;
         ss_discharge_2v45_o  <= 1'b0;
         standby_rail_en_o    <= 1'b0;
         active_switch_gate_o <= 1'b0;
         dual_five_output_o   <= 1'b0;
         mem33_sleep_en_o     <= 1'b0;
         mem25_en_o           <= 1'b0;
         clock_rail_output_o  <= 1'b0;
         fault_o              <= 1'b0;
         in_sleep_s5_o        <= 1'b0;
      end else begin
         st_q                 <= st_d;
         tmr_q                <= tmr_d;
         d5_q                 <= d5_d;
         dual5_pass_q         <= dual5_pass_d;
         mem_sel_q            <= mem_sel_d;
         sb_armed_q           <= sb_armed_d;
         all_armed_q          <= all_armed_d;
         disch_q              <= disch_d;
         forced_q             <= forced_d;
         loss_q               <= loss_d;
         loff_q               <= loff_d;
         hot_q                <= hot_d;
         ss_fast_charge_o     <= ss_fast_d;
         ss_slow_charge_o     <= ss_slow_d;
         ss_discharge_1v25_o  <= d125_d;
         ss_discharge_2v45_o  <= d245_d;
         standby_rail_en_o    <= sb_en_d;
         active_switch_gate_o <= gate_d;
         dual_five_output_o   <= d5o_d;
         mem33_sleep_en_o     <= m33_d;
         mem25_en_o           <= m25_d;
         clock_rail_output_o  <= clk_d;
         fault_o              <= flt_d;
         in_sleep_s5_o        <= s5o_d;
      end
   end
endmodule : ars_sequencer

// *** verification/acpi_rail_sequencer_bench.sv ***
// Self-checking bench of the rail sequencer.
`timescale 1ns/1ps
module acpi_rail_sequencer_bench;
   localparam int SLP = ars_pkg::SLEEP_DELAY_CYC + ars_pkg::DEGLITCH_CYC;
   // Rows: S3 req, S5 req, dual select, then gate, dual 5V, clock, S5 flag.
   localparam logic [6:0] ROWS [7] = '{7'h6e, 7'h20, 7'h6e, 7'h01, 7'h6e, 7'h7e, 7'h34};
   logic       clk, rst, bias, s3n, s5n, d5, main, pull, tw, ts;
   logic [4:0] uv;
   logic [1:0] ms;
   logic       f1, sl, d1, d2, a1, a2, a3, sd;
   logic       sbr, gate, dual, m25, m33, clkr, flt, s5;
   int         errors, num_checks, n, i;
   ars_sequencer #(.LATCH_CYC(20), .ACTIVE_CYC(30)) u_dut (
      .clk_i(clk), .sys_rst_i(rst), .bias_por_ok_i(bias), .suspend_ram_request_n_i(s3n),
      .soft_off_request_n_i(s5n), .dual5_sleep_support_i(d5), .memory_rail_select_i(ms),
      .main_inputs_ok_i(main), .ss_above_1v_i(a1), .ss_above_1v25_i(a2),
      .ss_above_2v75_i(a3), .ss_shutdown_i(sd), .rail_uv_i(uv), .temp_warn_i(tw),
      .temp_shut_i(ts), .ss_fast_charge_o(f1), .ss_slow_charge_o(sl),
      .ss_discharge_1v25_o(d1), .ss_discharge_2v45_o(d2), .standby_rail_en_o(sbr),
      .active_switch_gate_o(gate), .dual_five_output_o(dual), .mem33_sleep_en_o(m33),
      .mem25_en_o(m25), .clock_rail_output_o(clkr), .fault_o(flt), .in_sleep_s5_o(s5));
   ars_ss_model u_ss (
      .clk_i(clk), .pull_low_i(pull), .fast_i(f1), .slow_i(sl), .dis125_i(d1),
      .dis245_i(d2), .above_1v_o(a1), .above_1v25_o(a2), .above_2v75_o(a3),
      .shutdown_o(sd));
   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Steps past rising edges, then a fixed small delay before driving.
   task tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : tick
   // Compares one seen bit with its expected value.
   task chk(input string nm, input logic s, input logic e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s exp %b seen %b", nm, e, s);
      end
   endtask : chk
   // Prints the counts and the verdict, then ends the run.
   task test_done();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   // Waits a bounded time for the switch gate to reach a level.
   task wait_gate(input logic v, input int lim);
      n = 0;
      while (gate !== v && n < lim) begin
         tick(1);
         n++;
      end
      if (gate !== v) begin
         chk("gate wait", gate, v);
         test_done();
      end
   endtask : wait_gate
   // Main sequence: table rows first, then the awkward cases.
   initial begin
      {rst, bias, s3n, s5n, d5, main, pull, tw, ts, uv} = {1'b1, 1'b0, 7'h78, 5'h00};
      ms = 2'h3;
      tick(8);
      chk("gate in reset", gate, 1'b0);
      rst = 1'b0;
      tick(5);
      chk("standby no bias", sbr, 1'b0);
      bias = 1'b1;
      wait_gate(1'b1, 5000);
      chk("standby up", sbr, 1'b1);
      for (i = 0; i < 7; i++) begin
         {s3n, s5n, d5} = ROWS[i][6:4];
         wait_gate(ROWS[i][3], 25000);
         if (i == 1) chk("s3 delay", n >= SLP && n <= SLP + 60, 1'b1);
         tick(3);
         chk("gate", gate, ROWS[i][3]);
         chk("dual5", dual, ROWS[i][2]);
         chk("clock", clkr, ROWS[i][1]);
         chk("s5", s5, ROWS[i][0]);
         chk("mem33", m33, !ROWS[i][3]);
         chk("fault", flt, 1'b0);
      end
      {d5, s5n} = 2'h0;
      ms = 2'h1;
      tick(500);
      chk("dual5 sleep change", dual, 1'b1);
      chk("mem33 select held", m33, 1'b1);
      chk("s3 to s5", s5, 1'b0);
      {s3n, s5n} = 2'h3;
      wait_gate(1'b1, 2000);
      s5n = 1'b0;
      tick(3000);
      chk("illegal gate", gate, 1'b1);
      chk("illegal s5", s5, 1'b0);
      s5n = 1'b1;
      s3n = 1'b0;
      wait_gate(1'b0, 25000);
      tick(3);
      chk("dual5 new select", dual, 1'b0);
      chk("mem33 s3 select", m33, 1'b1);
      s3n = 1'b1;
      wait_gate(1'b1, 2000);
      uv = 5'h10;
      tick(5);
      chk("ext uv fault", flt, 1'b1);
      chk("ext uv gate", gate, 1'b1);
      uv = 5'h00;
      tick(5);
      chk("uv fault clear", flt, 1'b0);
      chk("mem25 on", m25, 1'b1);
      uv = 5'h04;
      tick(5);
      chk("int uv fault", flt, 1'b1);
      uv = 5'h00;
      tick(5);
      chk("mem25 latched", m25, 1'b0);
      pull = 1'b1;
      tick(5);
      chk("sd fault", flt, 1'b0);
      chk("sd gate", gate, 1'b0);
      chk("sd standby", sbr, 1'b0);
      pull = 1'b0;
      wait_gate(1'b1, 5000);
      chk("mem25 released", m25, 1'b1);
      tw = 1'b1;
      tick(5);
      chk("warm fault", flt, 1'b1);
      chk("warm gate", gate, 1'b1);
      ts = 1'b1;
      tick(5);
      chk("hot gate", gate, 1'b0);
      chk("hot standby", sbr, 1'b0);
      {ts, tw} = 2'h0;
      wait_gate(1'b1, 5000);
      chk("cool fault", flt, 1'b0);
      main = 1'b0;
      tick(100);
      chk("loss s5", s5, 1'b1);
      chk("loss fault", flt, 1'b1);
      chk("loss gate", gate, 1'b0);
      chk("loss mem33", m33, 1'b0);
      chk("loss mem25", m25, 1'b1);
      main = 1'b1;
      wait_gate(1'b1, 5000);
      chk("input wait", n >= 30, 1'b1);
      chk("s5 left", s5, 1'b0);
      bias = 1'b0;
      tick(5);
      chk("bias gone", sbr | gate, 1'b0);
      test_done();
   end
endmodule : acpi_rail_sequencer_bench

// *** verification/ars_sequencer_assertions.sv ***
// Checker of the rail sequencer port behaviour.
`timescale 1ns/1ps
module ars_sequencer_assertions #(
   parameter int unsigned ACTIVE_CYC = ars_pkg::ACTIVE_WAIT_CYC  // Active wait length
) (
   input wire logic clk_i,                    // Clock
   input wire logic sys_rst_i,                // Reset
   input wire logic bias_por_ok_i,            // Bias good
   input wire logic suspend_ram_request_n_i,  // S3 request
   input wire logic main_inputs_ok_i,         // Main inputs good
   input wire logic ss_shutdown_i,            // Node pulled low
   input wire logic temp_warn_i,              // Warm
   input wire logic temp_shut_i,              // Hot
   input wire logic active_switch_gate_o,     // Switch gate
   input wire logic dual_five_output_o,       // Dual 5V
   input wire logic clock_rail_output_o,      // Clock rail
   input wire logic standby_rail_en_o,        // Standby rail
   input wire logic fault_o,                  // Fault
   input wire logic in_sleep_s5_o             // S5 flag
);
   localparam int unsigned SLP = ars_pkg::SLEEP_DELAY_CYC + ars_pkg::DEGLITCH_CYC;
   int unsigned ok_q;
   int unsigned low_q;
   // Count how long the main inputs and the S3 request have held their level.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !main_inputs_ok_i) ok_q <= 0;
      else if (ok_q < ACTIVE_CYC) ok_q <= ok_q + 1;
      if (sys_rst_i || suspend_ram_request_n_i) low_q <= 0;
      else if (low_q < SLP) low_q <= low_q + 1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_gate_wait: assert property ($rose(active_switch_gate_o) |-> ok_q >= ACTIVE_CYC)
      else $error("Switch gate rose before the active wait ran out.");
   a_sleep_delay: assert property ($fell(active_switch_gate_o) && $past(main_inputs_ok_i) &&
      $past(bias_por_ok_i) && !ss_shutdown_i && !$past(ss_shutdown_i) && !$past(temp_shut_i)
      |-> low_q >= SLP)
      else $error("Switch gate fell before the sleep delay ran out.");
   a_clock_gate: assert property (clock_rail_output_o |-> active_switch_gate_o)
      else $error("Clock rail on outside active state.");
   a_s5_outputs: assert property (in_sleep_s5_o |-> !active_switch_gate_o && !clock_rail_output_o)
      else $error("Active outputs on in S5.");
   a_dual_active: assert property (active_switch_gate_o [*2] |-> dual_five_output_o)
      else $error("Dual 5V off in active state.");
   a_shutdown_off: assert property (ss_shutdown_i [*3] |-> !fault_o && !standby_rail_en_o &&
      !active_switch_gate_o && !dual_five_output_o)
      else $error("Outputs or fault on while node pulled low.");
   a_bias_off: assert property (!bias_por_ok_i [*3] |-> !standby_rail_en_o && !active_switch_gate_o)
      else $error("Rails on without bias.");
   a_hot_off: assert property (temp_shut_i [*3] |-> !standby_rail_en_o && !active_switch_gate_o)
      else $error("Rails on above the shutdown temperature.");
   a_warm_fault: assert property ((temp_warn_i && bias_por_ok_i && !ss_shutdown_i) [*3] |-> fault_o)
      else $error("No fault report while warm.");
   a_input_loss: assert property (!main_inputs_ok_i && active_switch_gate_o && !ss_shutdown_i
      |-> ##[1:3] in_sleep_s5_o && fault_o)
      else $error("Input loss in active did not force S5 with fault.");
   c_gate_up: cover property ($rose(active_switch_gate_o));
   c_s5_in: cover property ($rose(in_sleep_s5_o));
   c_fault: cover property ($rose(fault_o));
endmodule : ars_sequencer_assertions
bind ars_sequencer ars_sequencer_assertions #(.ACTIVE_CYC(ACTIVE_CYC)) u_chk (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bias_por_ok_i(bias_por_ok_i),
   .suspend_ram_request_n_i(suspend_ram_request_n_i), .main_inputs_ok_i(main_inputs_ok_i),
   .ss_shutdown_i(ss_shutdown_i), .temp_warn_i(temp_warn_i), .temp_shut_i(temp_shut_i),
   .active_switch_gate_o(active_switch_gate_o), .dual_five_output_o(dual_five_output_o),
   .clock_rail_output_o(clock_rail_output_o), .standby_rail_en_o(standby_rail_en_o),
   .fault_o(fault_o), .in_sleep_s5_o(in_sleep_s5_o));

// *** verification/ars_ss_model.sv ***
// Soft-start capacitor model driven by the sequencer charge outputs.
`timescale 1ns/1ps
module ars_ss_model (
   input  wire logic clk_i,        // Clock
   input  wire logic pull_low_i,   // External pull-down of the node
   input  wire logic fast_i,       // Fast charge
   input  wire logic slow_i,       // Slow charge
   input  wire logic dis125_i,     // Discharge to 1.25 V
   input  wire logic dis245_i,     // Discharge to 2.45 V
   output logic      above_1v_o,   // Node above 1 V
   output logic      above_1v25_o, // Node above 1.25 V
   output logic      above_2v75_o, // Node above 2.75 V
   output logic      shutdown_o    // Node held below 0.8 V
);
   logic [8:0] lvl_q = '0;
   // Node level in steps of 10 mV; a pull-down wins over any charge.
   always_ff @(posedge clk_i) begin
      if (pull_low_i) lvl_q <= '0;
      else if (dis125_i) lvl_q <= 9'h07d;
      else if (dis245_i && lvl_q > 9'h0f5) lvl_q <= 9'h0f5;
      else if (fast_i && lvl_q < 9'h064) lvl_q <= lvl_q + 9'h00a;
      else if (slow_i && lvl_q < 9'h12c) lvl_q <= lvl_q + 9'h001;
   end
   // Comparator flags seen by the sequencer.
   assign above_1v_o   = lvl_q >= 9'h064;
   assign above_1v25_o = lvl_q >= 9'h07d;
   assign above_2v75_o = lvl_q >= 9'h113;
   assign shutdown_o   = pull_low_i;
endmodule : ars_ss_model
